// ---- design/ckc_pkg.sv ----
// Package for the clock source and PLL control block: register map, field layout,
// reset values, mux codes, relock timing and the state types of both modules.
// Assumes a single 25 MHz system clock and byte addresses on the register bus.
package ckc_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 25000000;
  localparam int RELOCK_TIME_NS = 40000;
  localparam int RELOCK_CYCLES = RELOCK_TIME_NS / (1000000000 / CLK_FREQ_HZ);
  localparam int CNT_W = 16;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CLOCK_SOURCE = 8'h28;
  localparam logic [7:0] OFS_CORE_PLL = 8'h60;
  localparam logic [7:0] OFS_AUX_PLL = 8'h64;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EXT1_MUX_LSB = 27;
  localparam int EXT1_RATIO_BIT = 26;
  localparam int EXT1_USE_BIT = 25;
  localparam int EXT0_MUX_LSB = 22;
  localparam int EXT0_RATIO_BIT = 21;
  localparam int EXT0_USE_BIT = 20;
  localparam int DISP_MUX_LSB = 2;
  localparam int DISP_RATIO_BIT = 1;
  localparam int DISP_USE_BIT = 0;
  localparam int MULT_W = 6;
  localparam logic [31:0] CLOCK_SOURCE_MASK = 32'h3FF0001F;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [5:0] CORE_PLL_RESET = 6'h10;
  localparam logic [5:0] AUX_PLL_RESET = 6'h00;
  localparam logic [31:0] CLOCK_SOURCE_RESET = 32'h00000000;

  // ****************************************
  // Mux select codes
  // ****************************************
  localparam logic [2:0] MUX_NONE = 3'h0;
  localparam logic [2:0] MUX_AUX = 3'h1;
  localparam logic [2:0] MUX_FREQ_GENERATOR_OUT_0 = 3'h2;

  // ****************************************
  // State types
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] clock_source;
    logic [5:0] core_mult;
    logic [5:0] aux_mult;
    logic aux_enable;
    logic halt;
    logic [CNT_W-1:0] halt_cnt;
    logic aux_unstable;
    logic [CNT_W-1:0] aux_cnt;
  } ckc_ctl_state_type;

  typedef struct packed {
    logic src_prev;
    logic [1:0] div_cnt;
    logic clk_out;
  } ckc_sel_state_type;

endpackage

// ---- design/ckc_sel_if.sv ----
// Interface between the register block and one clock source selector.
// Assumes the control side drives the configuration from its own flip-flops.
`timescale 1ns/1ps
`default_nettype none
interface ckc_sel_if;
  logic [2:0] mux_select;
  logic divide_ratio;
  logic divider_use;
  logic clk_out;
  modport ctrl (output mux_select, output divide_ratio, output divider_use, input clk_out);
  modport selector (input mux_select, input divide_ratio, input divider_use, output clk_out);
endinterface
`default_nettype wire

// ---- design/ckc_clock_selector.sv ----
// One clock source selector: 3-bit mux, divide-by-2-or-4 stage and bypass.
// Assumes the aux clock and generator outputs are levels synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ckc_clock_selector (
  input wire logic sys_clk,
  input wire logic srst,
  ckc_sel_if.selector sel,
  input wire logic aux_clk,
  input wire logic [5:0] freq_gen
);

  // ****************************************
  // Source mux
  // ****************************************
  function automatic logic ckc_pick(input logic [2:0] m, input logic a, input logic [5:0] f);
    case (m)
      ckc_pkg::MUX_NONE: ckc_pick = 1'h0;
      ckc_pkg::MUX_AUX: ckc_pick = a;
      default: ckc_pick = f[m - ckc_pkg::MUX_FREQ_GENERATOR_OUT_0];
    endcase
  endfunction

  ckc_pkg::ckc_sel_state_type s;
  ckc_pkg::ckc_sel_state_type next_s;
  logic src;
  logic rise;

  assign src = ckc_pick(sel.mux_select, aux_clk, freq_gen);
  assign rise = src & ~s.src_prev;
  assign sel.clk_out = s.clk_out;

  // ****************************************
  // Divider and output stage
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.src_prev = src;
    if (sel.mux_select == ckc_pkg::MUX_NONE) begin
      // Parked low so a downstream peripheral sees no stray edge
      next_s.div_cnt = 2'h0;
      next_s.clk_out = 1'h0;
    end else begin
      if (rise) begin
        next_s.div_cnt = s.div_cnt + 2'h1;
      end
      if (!sel.divider_use) begin
        next_s.clk_out = src;
      end else begin
        next_s.clk_out = sel.divide_ratio ? next_s.div_cnt[0] : next_s.div_cnt[1];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  no_clock_low_a: assert property ((sel.mux_select == ckc_pkg::MUX_NONE) |=> !sel.clk_out)
    else $error("Selector output not low with no clock selected");
  bypass_follows_a: assert property ((sel.mux_select != ckc_pkg::MUX_NONE && !sel.divider_use)
    |=> sel.clk_out == $past(src))
    else $error("Bypassed output does not follow mux source");
  div_two_edge_a: assert property ((sel.mux_select != ckc_pkg::MUX_NONE && sel.divider_use && sel.divide_ratio
    && !rise && $stable(sel.mux_select) && $stable(sel.divider_use) && $stable(sel.divide_ratio))
    |=> $stable(sel.clk_out))
    else $error("Divided output changed without a source edge");

endmodule
`default_nettype wire

// ---- design/ckc_clock_control.sv ----
// Clock source and PLL control: Avalon-MM register slave holding the core PLL
// and auxiliary PLL multipliers and the clock source select register, the
// relock halt timers and three clock source selectors.
// Assumes inputs synchronous to sys_clk and an Avalon master that holds its
// request until waitrequest is sampled low.
//
// Contract
// - Bits 29:27 select ext1 clock mux input
// - Bit 26 ext1 ratio, 0 div4, 1 div2
// - Bit 25 ext1 bypass when 0, divider when 1
// - Bits 24:22 select ext0 clock mux input
// - Bit 21 ext0 ratio, 0 div4, 1 div2
// - Bit 20 ext0 bypass when 0, divider when 1
// - Bits 4:2 select display clock mux input
// - Bit 1 display ratio, 0 div4, 1 div2
// - Bit 0 display bypass when 0, divider when 1
// - Mux code 0 none, 1 aux, 2-7 generators
// - Core multiplier 6 bits, reset 16, rest zero
// - Aux multiplier zero disables auxiliary PLL
// - Core PLL write halts bus clocks 40 us
// - Core PLL reg resets on hardware reset only
// - Aux PLL resets on hardware, runtime, sleep
// - Aux PLL write does not halt system
// - Clock source resets on hardware reset only
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ckc_clock_control (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic runtime_rst,
  input wire logic sleep_exit,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic aux_clk,
  input wire logic [5:0] freq_gen,
  output logic [5:0] core_pll_mult,
  output logic [5:0] aux_pll_mult,
  output logic aux_pll_enable,
  output logic bus_clock_halt,
  output logic aux_clock_unstable,
  output logic external_clock_out_0,
  output logic external_clock_out_1,
  output logic serial_port0_clock,
  output logic serial_port1_clock,
  output logic display_clock
);

  localparam logic [ckc_pkg::CNT_W-1:0] RELOCK_LAST = ckc_pkg::CNT_W'(ckc_pkg::RELOCK_CYCLES - 1);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] ckc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    ckc_merge = r;
  endfunction

  ckc_pkg::ckc_ctl_state_type s;
  ckc_pkg::ckc_ctl_state_type next_s;
  logic req;
  logic [31:0] core_merged;
  logic [31:0] aux_merged;

  assign req = avs_read | avs_write;

  // ****************************************
  // Write merge
  // ****************************************
  // Lanes merge over the stored word, so a byte write keeps the fields it does not cover
  assign core_merged = ckc_merge({26'h0, s.core_mult}, avs_writedata, avs_byteenable);
  assign aux_merged = ckc_merge({26'h0, s.aux_mult}, avs_writedata, avs_byteenable);

  // ****************************************
  // Register bus and timers
  // ****************************************
  always_comb begin
    next_s = s;
    if (s.halt) begin
      if (s.halt_cnt == '0) begin
        next_s.halt = 1'h0;
      end else begin
        next_s.halt_cnt = s.halt_cnt - 1'h1;
      end
    end
    if (s.aux_unstable) begin
      if (s.aux_cnt == '0) begin
        next_s.aux_unstable = 1'h0;
      end else begin
        next_s.aux_cnt = s.aux_cnt - 1'h1;
      end
    end
    if (s.ack) begin
      // Write lands at the edge where the master sees waitrequest low
      next_s.ack = 1'h0;
      if (avs_write) begin
        case (avs_address)
          ckc_pkg::OFS_CLOCK_SOURCE: begin
            next_s.clock_source = ckc_merge(s.clock_source, avs_writedata, avs_byteenable)
              & ckc_pkg::CLOCK_SOURCE_MASK;
          end
          ckc_pkg::OFS_CORE_PLL: begin
            next_s.core_mult = core_merged[ckc_pkg::MULT_W-1:0];
            // Any write relocks, even with the same value, so software can force a halt
            next_s.halt = 1'h1;
            next_s.halt_cnt = RELOCK_LAST;
          end
          ckc_pkg::OFS_AUX_PLL: begin
            next_s.aux_mult = aux_merged[ckc_pkg::MULT_W-1:0];
            // No halt here; only a flag warns that aux-derived clocks may wobble
            next_s.aux_unstable = 1'h1;
            next_s.aux_cnt = RELOCK_LAST;
          end
          default: begin
          end
        endcase
      end
    end else if (req && !s.halt) begin
      // Bus clocks stand still during relock, so no access is granted then
      next_s.ack = 1'h1;
      if (avs_read) begin
        case (avs_address)
          ckc_pkg::OFS_CLOCK_SOURCE: next_s.rdata = s.clock_source;
          ckc_pkg::OFS_CORE_PLL: next_s.rdata = {26'h0, s.core_mult};
          ckc_pkg::OFS_AUX_PLL: next_s.rdata = {26'h0, s.aux_mult};
          default: next_s.rdata = 32'h0;
        endcase
      end
    end
    // Runtime reset and sleep leave core PLL and clock source alone
    if (runtime_rst || sleep_exit) begin
      next_s.aux_mult = ckc_pkg::AUX_PLL_RESET;
      next_s.aux_unstable = 1'h0;
      next_s.aux_cnt = '0;
    end
    next_s.aux_enable = (next_s.aux_mult != 6'h0);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
      s.core_mult <= ckc_pkg::CORE_PLL_RESET;
      s.aux_mult <= ckc_pkg::AUX_PLL_RESET;
      s.clock_source <= ckc_pkg::CLOCK_SOURCE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Clock source selectors
  // ****************************************
  ckc_sel_if sel_bus[3] ();

  assign sel_bus[0].mux_select = s.clock_source[ckc_pkg::EXT0_MUX_LSB +: 3];
  assign sel_bus[0].divide_ratio = s.clock_source[ckc_pkg::EXT0_RATIO_BIT];
  assign sel_bus[0].divider_use = s.clock_source[ckc_pkg::EXT0_USE_BIT];
  assign sel_bus[1].mux_select = s.clock_source[ckc_pkg::EXT1_MUX_LSB +: 3];
  assign sel_bus[1].divide_ratio = s.clock_source[ckc_pkg::EXT1_RATIO_BIT];
  assign sel_bus[1].divider_use = s.clock_source[ckc_pkg::EXT1_USE_BIT];
  assign sel_bus[2].mux_select = s.clock_source[ckc_pkg::DISP_MUX_LSB +: 3];
  assign sel_bus[2].divide_ratio = s.clock_source[ckc_pkg::DISP_RATIO_BIT];
  assign sel_bus[2].divider_use = s.clock_source[ckc_pkg::DISP_USE_BIT];

  for (genvar i = 0; i < 3; i++) begin : g_sel
    ckc_clock_selector u_sel (
      .sys_clk(sys_clk),
      .srst(srst),
      .sel(sel_bus[i]),
      .aux_clk(aux_clk),
      .freq_gen(freq_gen)
    );
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = ~s.ack;
  assign core_pll_mult = s.core_mult;
  assign aux_pll_mult = s.aux_mult;
  assign aux_pll_enable = s.aux_enable;
  assign bus_clock_halt = s.halt;
  assign aux_clock_unstable = s.aux_unstable;
  assign external_clock_out_0 = sel_bus[0].clk_out;
  assign serial_port0_clock = sel_bus[0].clk_out;
  assign external_clock_out_1 = sel_bus[1].clk_out;
  assign serial_port1_clock = sel_bus[1].clk_out;
  assign display_clock = sel_bus[2].clk_out;

  // ****************************************
  // Checks
  // ****************************************
  logic [ckc_pkg::CNT_W-1:0] halt_age;
  logic [ckc_pkg::CNT_W-1:0] aux_age;
  logic aux_grant_wr;

  assign aux_grant_wr = !avs_waitrequest && avs_write && avs_address == ckc_pkg::OFS_AUX_PLL;

  always_ff @(posedge sys_clk) begin
    if (srst || !s.halt) begin
      halt_age <= '0;
    end else begin
      halt_age <= halt_age + 1'h1;
    end
  end

  // Each aux write starts a fresh relock, so the age restarts on every granted write
  always_ff @(posedge sys_clk) begin
    if (srst || !s.aux_unstable || aux_grant_wr) begin
      aux_age <= '0;
    end else begin
      aux_age <= aux_age + 1'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  halt_start_a: assert property ((!avs_waitrequest && avs_write && avs_address == ckc_pkg::OFS_CORE_PLL)
    |=> bus_clock_halt)
    else $error("Core PLL write did not start the halt");
  halt_length_a: assert property ($fell(bus_clock_halt)
    |-> $past(halt_age) == ckc_pkg::CNT_W'(ckc_pkg::RELOCK_CYCLES - 1))
    else $error("Halt did not last the relock time");
  halt_no_grant_a: assert property (bus_clock_halt |-> avs_waitrequest)
    else $error("Access granted during halt");
  aux_no_halt_a: assert property ((!avs_waitrequest && avs_write && avs_address == ckc_pkg::OFS_AUX_PLL
    && !bus_clock_halt) |=> !bus_clock_halt ##1 !bus_clock_halt)
    else $error("Aux PLL write halted the bus");
  aux_rt_reset_a: assert property ((runtime_rst || sleep_exit) |=> aux_pll_mult == ckc_pkg::AUX_PLL_RESET
    && !aux_pll_enable)
    else $error("Aux PLL not reset by runtime reset or sleep");
  core_keep_a: assert property ((runtime_rst && (avs_waitrequest || !avs_write)) |=> $stable(core_pll_mult))
    else $error("Core PLL changed on runtime reset");
  source_keep_a: assert property ((runtime_rst && (avs_waitrequest || !avs_write)) |=> $stable(s.clock_source))
    else $error("Clock source changed on runtime reset");
  core_read_a: assert property ((avs_waitrequest && avs_read && !bus_clock_halt
    && avs_address == ckc_pkg::OFS_CORE_PLL) |=> avs_readdata == {26'h0, core_pll_mult})
    else $error("Core PLL read data wrong");
  aux_enable_a: assert property (aux_pll_enable == (aux_pll_mult != 6'h0))
    else $error("Aux PLL enable does not match multiplier");

  // Bus answer timing
  grant_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low for more than one cycle");
  req_answer_a: assert property (((avs_read || avs_write) && avs_waitrequest && !bus_clock_halt)
    |=> !avs_waitrequest)
    else $error("Request not answered outside a halt");
  readdata_hold_a: assert property (!(avs_read && avs_waitrequest && !bus_clock_halt)
    |=> $stable(avs_readdata))
    else $error("Read data changed without a read");

  // Register contents
  core_write_a: assert property ((!avs_waitrequest && avs_write && avs_address == ckc_pkg::OFS_CORE_PLL
    && avs_byteenable[0]) |=> core_pll_mult == $past(avs_writedata[5:0]))
    else $error("Core PLL write did not land");
  core_hold_a: assert property (bus_clock_halt |=> $stable(core_pll_mult))
    else $error("Core PLL changed during relock");
  aux_write_a: assert property ((aux_grant_wr && avs_byteenable[0] && !runtime_rst && !sleep_exit)
    |=> aux_pll_mult == $past(avs_writedata[5:0]))
    else $error("Aux PLL write did not land");
  source_write_a: assert property ((!avs_waitrequest && avs_write
    && avs_address == ckc_pkg::OFS_CLOCK_SOURCE && avs_byteenable == 4'hF)
    |=> s.clock_source == ($past(avs_writedata) & ckc_pkg::CLOCK_SOURCE_MASK))
    else $error("Clock source write did not land");
  source_read_a: assert property ((avs_waitrequest && avs_read && !bus_clock_halt
    && avs_address == ckc_pkg::OFS_CLOCK_SOURCE) |=> avs_readdata == $past(s.clock_source))
    else $error("Clock source read data wrong");
  aux_read_a: assert property ((avs_waitrequest && avs_read && !bus_clock_halt
    && avs_address == ckc_pkg::OFS_AUX_PLL) |=> avs_readdata == {26'h0, $past(aux_pll_mult)})
    else $error("Aux PLL read data wrong");

  // Reset and relock
  aux_unstable_a: assert property ((aux_grant_wr && !runtime_rst && !sleep_exit)
    |=> aux_clock_unstable)
    else $error("Aux write did not flag relock");
  aux_length_a: assert property (($fell(aux_clock_unstable) && !$past(runtime_rst || sleep_exit))
    |-> $past(aux_age) == ckc_pkg::CNT_W'(ckc_pkg::RELOCK_CYCLES - 1))
    else $error("Aux relock flag did not last the relock time");
  hard_reset_a: assert property (disable iff (1'b0) srst |=> core_pll_mult == ckc_pkg::CORE_PLL_RESET
    && aux_pll_mult == ckc_pkg::AUX_PLL_RESET && s.clock_source == ckc_pkg::CLOCK_SOURCE_RESET)
    else $error("Hard reset did not restore the registers");

endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the clock source and PLL control block.
// Assumes the design package, interface and modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, srst, runtime_rst, sleep_exit, avs_read, avs_write;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, aux_clk, aux_lvl, aux_run, aux_pll_enable, bus_clock_halt, aux_clock_unstable;
  logic [5:0] freq_gen, core_pll_mult, aux_pll_mult;
  logic external_clock_out_0, external_clock_out_1, serial_port0_clock, serial_port1_clock;
  logic display_clock;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;

  ckc_clock_control u_ckc_clock_control (.sys_clk(sys_clk), .srst(srst), .runtime_rst(runtime_rst),
    .sleep_exit(sleep_exit), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .aux_clk(aux_clk), .freq_gen(freq_gen),
    .core_pll_mult(core_pll_mult), .aux_pll_mult(aux_pll_mult), .aux_pll_enable(aux_pll_enable),
    .bus_clock_halt(bus_clock_halt), .aux_clock_unstable(aux_clock_unstable),
    .external_clock_out_0(external_clock_out_0), .external_clock_out_1(external_clock_out_1),
    .serial_port0_clock(serial_port0_clock), .serial_port1_clock(serial_port1_clock),
    .display_clock(display_clock));

  // ****************************************
  // Clock, source toggling and timeout
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Ceiling covers three relock waits plus the selector sweeps with margin
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    aux_clk <= aux_run ? ~aux_clk : aux_lvl;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_range(input string what, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low; gap cycle keeps drives apart
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d, output int waits);
    waits = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    if (is_wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge sys_clk);
      waits++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int w;
    bus(1'b1, a, d, w);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    int w;
    bus(1'b0, a, 32'h0, w);
    check(what, exp, q);
  endtask

  task automatic count_high(input int which, output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk);
      cnt++;
    end while ((which == 0 ? bus_clock_halt : aux_clock_unstable) === 1'b1 && cnt < 1100);
    cnt--;
  endtask

  function automatic logic sel_out(input int s);
    return (s == 0) ? display_clock : (s == 1) ? external_clock_out_0 : external_clock_out_1;
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values;
    rd(8'h60, 32'h10, "core pll reset");
    rd(8'h64, 32'h0, "aux pll reset");
    rd(8'h28, 32'h0, "clock source reset");
    rd(8'h3C, 32'h0, "unmapped read");
    check("aux enable at reset", 1'b0, aux_pll_enable);
    $display("done reset values");
  endtask

  task automatic t_core_halt;
    int w;
    wr(8'h60, 32'hFFFFFFE1);
    count_high(0, n);
    check_range("core halt length", 1000, 1000, n);
    check("core mult out", 6'h21, core_pll_mult);
    rd(8'h60, 32'h21, "core readback");
    wr(8'h60, 32'h21);
    bus(1'b0, 8'h60, 32'h0, w);
    check_range("read stalled by rewrite", 1000, 1002, w);
    check("read after halt", 32'h21, q);
    $display("done core halt");
  endtask

  task automatic t_aux;
    wr(8'h64, 32'hFFFFFF0C);
    @(posedge sys_clk);
    check("aux write no halt", 1'b0, bus_clock_halt);
    check("aux enable", 1'b1, aux_pll_enable);
    count_high(1, n);
    check_range("aux unstable length", 999, 1000, n);
    rd(8'h64, 32'h0C, "aux readback");
    wr(8'h64, 32'h0);
    @(posedge sys_clk);
    check("aux disabled", 1'b0, aux_pll_enable);
    wr(8'h28, 32'hFFFFFFFF);
    rd(8'h28, 32'h3FF0001F, "clock source reserved");
    for (int k = 0; k < 2; k++) begin
      wr(8'h64, 32'h8);
      if (k == 0) runtime_rst <= 1'b1;
      else sleep_exit <= 1'b1;
      @(posedge sys_clk);
      runtime_rst <= 1'b0;
      sleep_exit <= 1'b0;
      @(posedge sys_clk);
      check("aux mult soft reset", 6'h0, aux_pll_mult);
      check("aux enable soft reset", 1'b0, aux_pll_enable);
      check("core kept", 6'h21, core_pll_mult);
      rd(8'h28, 32'h3FF0001F, "clock source kept");
    end
    $display("done aux");
  endtask

  task automatic t_mux;
    logic [6:0] hot, pat;
    int base[3] = '{0, 20, 25};
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 8; c++) begin
        wr(8'h28, 32'(c) << (base[s] + 2));
        hot = (c == 0) ? 7'h00 : 7'h01 << (c - 1);
        for (int p = 0; p < 2; p++) begin
          pat = p ? ~hot : hot;
          aux_lvl <= pat[0];
          freq_gen <= pat[6:1];
          repeat (4) @(posedge sys_clk);
          check("selected source", (c != 0 && p == 0), sel_out(s));
          check("port0 mirror", external_clock_out_0, serial_port0_clock);
          check("port1 mirror", external_clock_out_1, serial_port1_clock);
        end
      end
    end
    $display("done mux");
  endtask

  task automatic t_divider;
    logic prev;
    int base[3] = '{0, 20, 25};
    int expn[4] = '{32, 8, 32, 16};
    aux_run <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      for (int m = 0; m < 4; m++) begin
        wr(8'h28, (32'h1 << (base[s] + 2)) | (32'(m) << base[s]));
        repeat (8) @(posedge sys_clk);
        prev = sel_out(s);
        n = 0;
        repeat (64) begin
          @(posedge sys_clk);
          if (sel_out(s) === 1'b1 && prev === 1'b0) n++;
          prev = sel_out(s);
        end
        check_range("output rising edges", expn[m] - 1, expn[m] + 1, n);
      end
    end
    aux_run <= 1'b0;
    $display("done divider");
  endtask

  task automatic t_hard_reset;
    wr(8'h64, 32'h8);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rd(8'h60, 32'h10, "core after hard reset");
    rd(8'h28, 32'h0, "source after hard reset");
    rd(8'h64, 32'h0, "aux after hard reset");
    $display("done hard reset");
  endtask

  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    srst = 1'b1;
    runtime_rst = 1'b0;
    sleep_exit = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    aux_lvl = 1'b0;
    aux_run = 1'b0;
    freq_gen = 6'h00;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset_values();
    t_core_halt();
    t_aux();
    t_mux();
    t_divider();
    t_hard_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
